// [rtl/pcc_top.sv]
`timescale 1ns/100ps
`include "pcc_consts.svh"
module pcc_top
  import pcc_pkg::*;
#(
  parameter int NUM_CHAN = 4
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] par_addr,
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [31:0] par_wdata,
  input  wire logic [31:0] pos_sample,
  input  wire logic        pos_valid,
  output logic [31:0]      par_rdata_ff,
  output logic             par_ack_ff,
  output logic             par_err_ff,
  output logic [3:0]       chan_status_ff
);

  // --------------------------------------------------------------------------
  // Address map per channel
  // --------------------------------------------------------------------------
  localparam logic [15:0] OFS_RUN  [4] = '{`PCC_OFS_CH1_RUN, `PCC_OFS_CH2_RUN,
                                           `PCC_OFS_CH3_RUN, `PCC_OFS_CH4_RUN};
  localparam logic [15:0] OFS_CRIT [4] = '{`PCC_OFS_CH1_CRIT, `PCC_OFS_CH2_CRIT,
                                           `PCC_OFS_CH3_CRIT, `PCC_OFS_CH4_CRIT};
  localparam logic [15:0] OFS_VA   [4] = '{`PCC_OFS_CH1_VAL_A, `PCC_OFS_CH2_VAL_A,
                                           `PCC_OFS_CH3_VAL_A, `PCC_OFS_CH4_VAL_A};
  localparam logic [15:0] OFS_VB   [4] = '{`PCC_OFS_CH1_VAL_B, `PCC_OFS_CH2_VAL_B,
                                           `PCC_OFS_CH3_VAL_B, `PCC_OFS_CH4_VAL_B};
  localparam logic [15:0] RST_CRIT [4] = '{`PCC_RST_CH1_CRIT, `PCC_RST_CH2_CRIT,
                                           `PCC_RST_CH3_CRIT, `PCC_RST_CH4_CRIT};

  // --------------------------------------------------------------------------
  // Shared state
  // --------------------------------------------------------------------------
  logic signed [31:0] pos_ff;
  logic [3:0]         group_ff;
  logic [3:0]         status_w;
  logic [3:0]         hit_run;
  logic [3:0]         hit_crit;
  logic [3:0]         hit_va;
  logic [3:0]         hit_vb;
  logic [31:0]        rd_run   [4];
  logic [31:0]        rd_crit  [4];
  logic [31:0]        rd_va    [4];
  logic [31:0]        rd_vb    [4];

  wire logic hit_group  = (par_addr == `PCC_OFS_GROUP_RUN);
  wire logic hit_status = (par_addr == `PCC_OFS_STATUS);
  wire logic hit_any    = (|hit_run) || (|hit_crit) || (|hit_va) || (|hit_vb)
                          || hit_group || hit_status;
  wire logic run_ok     = (par_wdata <= {16'h0000, `PCC_RUN_MAX});
  wire logic crit_ok    = (par_wdata <= {16'h0000, `PCC_CRIT_MAX});
  wire logic group_ok   = (par_wdata <= {16'h0000, `PCC_GROUP_MAX});
  // Out-of-range settings are refused and leave the old value in place
  wire logic bad_value  = ((|hit_run) && !run_ok) || ((|hit_crit) && !crit_ok)
                          || (hit_group && !group_ok) || hit_status;
  wire logic wr_err     = par_wr && (!hit_any || bad_value);
  wire logic rd_err     = par_rd && !hit_any;
  wire logic grp_we     = par_wr && hit_group && group_ok;

  // --------------------------------------------------------------------------
  // Position sample and group run mask capture
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pos_ff <= 32'sh00000000;
    end else if (pos_valid) begin
      pos_ff <= pos_sample;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      group_ff <= 4'h0;
    end else if (grp_we) begin
      group_ff <= par_wdata[3:0];
    end
  end

  // --------------------------------------------------------------------------
  // Channels
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    logic [1:0]         run_ff;
    logic [15:0]        crit_ff;
    logic signed [31:0] va_ff;
    logic signed [31:0] vb_ff;
    pcc_chan_cfg_t      cfg;

    assign hit_run[i]  = (par_addr == OFS_RUN[i]);
    assign hit_crit[i] = (par_addr == OFS_CRIT[i]);
    assign hit_va[i]   = (par_addr == OFS_VA[i]);
    assign hit_vb[i]   = (par_addr == OFS_VB[i]);

    wire logic run_we  = par_wr && hit_run[i] && run_ok;
    wire logic crit_we = par_wr && hit_crit[i] && crit_ok;
    wire logic va_we   = par_wr && hit_va[i];
    wire logic vb_we   = par_wr && hit_vb[i];

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        run_ff  <= 2'h0;
        crit_ff <= RST_CRIT[i];
        va_ff   <= `PCC_RST_VALUE;
        vb_ff   <= `PCC_RST_VALUE;
      end else begin
        if (run_we) begin
          run_ff <= par_wdata[1:0];
        end
        if (crit_we) begin
          crit_ff <= par_wdata[15:0];
        end
        if (va_we) begin
          va_ff <= par_wdata;
        end
        if (vb_we) begin
          vb_ff <= par_wdata;
        end
      end
    end

    assign cfg.crit     = pcc_crit_t'(crit_ff);
    assign cfg.val_a    = va_ff;
    assign cfg.val_b    = vb_ff;
    assign cfg.run      = pcc_run_t'(run_ff);
    assign cfg.group_on = group_ff[i];

    assign rd_run[i]  = {30'h00000000, run_ff};
    assign rd_crit[i] = {16'h0000, crit_ff};
    assign rd_va[i]   = va_ff;
    assign rd_vb[i]   = vb_ff;

    pcc_channel u_chan (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .cfg       (cfg),
      .act_pos   (pos_ff),
      .status_ff (status_w[i])
    );
  end

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h00000000;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (hit_run[i]) begin
        rd_mux = rd_run[i];
      end else if (hit_crit[i]) begin
        rd_mux = rd_crit[i];
      end else if (hit_va[i]) begin
        rd_mux = rd_va[i];
      end else if (hit_vb[i]) begin
        rd_mux = rd_vb[i];
      end
    end
    if (hit_group) begin
      rd_mux = {28'h0000000, group_ff};
    end else if (hit_status) begin
      rd_mux = {28'h0000000, status_w};
    end
  end

  // --------------------------------------------------------------------------
  // Parameter port answer
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      par_rdata_ff   <= 32'h00000000;
      par_ack_ff     <= 1'b0;
      par_err_ff     <= 1'b0;
      chan_status_ff <= 4'h0;
    end else begin
      par_ack_ff     <= par_wr || par_rd;
      par_err_ff     <= wr_err || rd_err;
      chan_status_ff <= status_w;
      if (par_rd && hit_any) begin
        par_rdata_ff <= rd_mux;
      end
    end
  end

endmodule : pcc_top

// [rtl/pcc_consts.svh]
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Parameter addresses
// ----------------------------------------------------------------------------
`define PCC_OFS_CH1_RUN      16'hB04
`define PCC_OFS_CH2_RUN      16'hB06
`define PCC_OFS_CH3_RUN      16'hB18
`define PCC_OFS_CH4_RUN      16'hB1A
`define PCC_OFS_CH1_CRIT     16'hB08
`define PCC_OFS_CH2_CRIT     16'hB0A
`define PCC_OFS_CH3_CRIT     16'hB1C
`define PCC_OFS_CH4_CRIT     16'hB1E
`define PCC_OFS_CH1_VAL_A    16'hB10
`define PCC_OFS_CH1_VAL_B    16'hB12
`define PCC_OFS_CH2_VAL_A    16'hB14
`define PCC_OFS_CH2_VAL_B    16'hB16
`define PCC_OFS_CH3_VAL_A    16'hB24
`define PCC_OFS_CH3_VAL_B    16'hB26
`define PCC_OFS_CH4_VAL_A    16'hB28
`define PCC_OFS_CH4_VAL_B    16'hB2A
`define PCC_OFS_GROUP_RUN    16'hB2C
`define PCC_OFS_STATUS       16'hB2E

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define PCC_RST_CH1_CRIT     16'h0005
`define PCC_RST_CH2_CRIT     16'h0000
`define PCC_RST_CH3_CRIT     16'h0000
`define PCC_RST_CH4_CRIT     16'h0000
`define PCC_RST_VALUE        32'h00000000
`define PCC_RST_RUN          16'h0000
`define PCC_RST_GROUP        16'h0000
`define PCC_CRIT_MAX         16'h0005
`define PCC_RUN_MAX          16'h0003
`define PCC_GROUP_MAX        16'h000F

`endif

// [rtl/pcc_pkg.sv]
package pcc_pkg;

  typedef enum logic [15:0] {
    PCC_CRIT_GE_A       = 16'h0000,
    PCC_CRIT_LE_A       = 16'h0001,
    PCC_CRIT_IN_BASIC   = 16'h0002,
    PCC_CRIT_OUT_BASIC  = 16'h0003,
    PCC_CRIT_IN_EXT     = 16'h0004,
    PCC_CRIT_OUT_EXT    = 16'h0005
  } pcc_crit_t;

  typedef enum logic [1:0] {
    PCC_RUN_OFF_HOLD = 2'h0,
    PCC_RUN_ON       = 2'h1,
    PCC_RUN_OFF_LOW  = 2'h2,
    PCC_RUN_OFF_HIGH = 2'h3
  } pcc_run_t;

  typedef struct packed {
    pcc_crit_t          crit;
    logic signed [31:0] val_a;
    logic signed [31:0] val_b;
    pcc_run_t           run;
    logic               group_on;
  } pcc_chan_cfg_t;

endpackage : pcc_pkg

// [rtl/pcc_channel.sv]
`timescale 1ns/100ps
module pcc_channel
  import pcc_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire pcc_chan_cfg_t      cfg,
  input  wire logic signed [31:0] act_pos,
  output logic                    status_ff
);

  // --------------------------------------------------------------------------
  // Comparisons
  // --------------------------------------------------------------------------
  wire logic        ge_a     = (act_pos >= cfg.val_a);
  wire logic        le_a     = (act_pos <= cfg.val_a);
  wire logic        le_b     = (act_pos <= cfg.val_b);
  wire logic        in_basic = ge_a && le_b;
  // Offset from A modulo 2^32, so a span that wraps past the range end still works
  wire logic [31:0] ofs_pos  = act_pos - cfg.val_a;
  wire logic [31:0] ofs_b    = cfg.val_b - cfg.val_a;
  wire logic        in_ext   = (ofs_pos <= ofs_b);
  wire logic        active   = (cfg.run == PCC_RUN_ON) || cfg.group_on;

  logic hit;
  logic nxt_status;

  always_comb begin
    case (cfg.crit)
      PCC_CRIT_GE_A:      hit = ge_a;
      PCC_CRIT_LE_A:      hit = le_a;
      PCC_CRIT_IN_BASIC:  hit = in_basic;
      PCC_CRIT_OUT_BASIC: hit = !in_basic;
      PCC_CRIT_IN_EXT:    hit = in_ext;
      PCC_CRIT_OUT_EXT:   hit = !in_ext;
      default:            hit = 1'b0;
    endcase
  end

  always_comb begin
    if (active) begin
      nxt_status = hit;
    end else if (cfg.run == PCC_RUN_OFF_LOW) begin
      nxt_status = 1'b0;
    end else if (cfg.run == PCC_RUN_OFF_HIGH) begin
      nxt_status = 1'b1;
    end else begin
      nxt_status = status_ff;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
    end
  end

endmodule : pcc_channel

// [test/pcc_top_properties.sv]
`timescale 1ns/100ps
module pcc_top_properties
  import pcc_pkg::*;
#(
  parameter int NUM_CHAN = 4
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [15:0] par_addr,
  input wire logic        par_wr,
  input wire logic        par_rd,
  input wire logic [31:0] par_wdata,
  input wire logic [31:0] pos_sample,
  input wire logic        pos_valid,
  input wire logic [31:0] par_rdata_ff,
  input wire logic        par_ack_ff,
  input wire logic        par_err_ff,
  input wire logic [3:0]  chan_status_ff
);
  // ----
  // Access answers, limits and status stability
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_ack_next: assert property ((par_wr || par_rd) |=> par_ack_ff)
    else $error("no ack after access");
  chk_ack_only_req: assert property (!(par_wr || par_rd) |=> !par_ack_ff)
    else $error("ack without access");
  chk_err_with_ack: assert property (par_err_ff |-> par_ack_ff)
    else $error("err without ack");
  chk_crit_refused: assert property (par_wr && par_addr == 16'hB08 &&
    par_wdata[15:0] > 16'h0005 |=> par_err_ff) else $error("bad code taken");
  chk_crit_taken: assert property (par_wr && par_addr == 16'hB08 &&
    par_wdata[31:0] <= 32'h5 |=> !par_err_ff) else $error("good code refused");
  chk_run_refused: assert property (par_wr && par_addr == 16'hB06 &&
    par_wdata[15:0] > 16'h0003 |=> par_err_ff) else $error("bad run taken");
  chk_group_refused: assert property (par_wr && par_addr == 16'hB2C &&
    par_wdata[15:0] > 16'h000F |=> par_err_ff) else $error("bad mask taken");
  chk_rdata_hold: assert property (!par_rd |=> $stable(par_rdata_ff))
    else $error("read data moved");
  chk_status_quiet: assert property ((!pos_valid && !par_wr) [*4]
    |=> $stable(chan_status_ff)) else $error("status moved while quiet");
  cover property (par_err_ff);
  cover property ($rose(chan_status_ff[0]));
  cover property (par_rd ##1 par_ack_ff);
endmodule : pcc_top_properties
bind pcc_top pcc_top_properties #(.NUM_CHAN(NUM_CHAN)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .par_addr(par_addr), .par_wr(par_wr),
  .par_rd(par_rd), .par_wdata(par_wdata), .pos_sample(pos_sample),
  .pos_valid(pos_valid), .par_rdata_ff(par_rdata_ff), .par_ack_ff(par_ack_ff),
  .par_err_ff(par_err_ff), .chan_status_ff(chan_status_ff));

// [test/pcc_master_model.sv]
`timescale 1ns/100ps
module pcc_master_model
  import pcc_pkg::*;
(
  input  wire logic        ref_clk,
  output logic [15:0]      par_addr,
  output logic             par_wr,
  output logic             par_rd,
  output logic [31:0]      par_wdata,
  input  wire logic [31:0] par_rdata_ff,
  input  wire logic        par_ack_ff,
  input  wire logic        par_err_ff
);
  // ----
  // One access: one-cycle strobe, answer taken when ack is seen
  // ----
  initial begin
    par_addr = 16'h0;
    par_wr = 1'b0;
    par_rd = 1'b0;
    par_wdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(negedge ref_clk);
    par_addr = a;
    par_wdata = d;
    par_wr = w;
    par_rd = !w;
    @(negedge ref_clk);
    par_wr = 1'b0;
    par_rd = 1'b0;
    // Released lines show the inverse of the last value
    par_addr = ~a;
    par_wdata = ~d;
    while (par_ack_ff !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    q = par_rdata_ff;
    e = (n < 4) ? par_err_ff : 1'bx;
  endtask : xfer
endmodule : pcc_master_model

// [test/position_compare_channels_test.sv]
`timescale 1ns/100ps
module position_compare_channels_test
  import pcc_pkg::*;
;
  typedef struct packed {
    logic [15:0] c;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] p;
    logic        e;
  } pcc_row_t;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] pos_sample = 32'h0;
  logic        pos_valid = 1'b0;
  logic [15:0] par_addr;
  logic        par_wr, par_rd, par_ack_ff, par_err_ff;
  logic [31:0] par_wdata, par_rdata_ff;
  logic [3:0]  chan_status_ff;
  int          fails = 0;
  int          n_checks = 0;
  pcc_row_t    rows [14] = '{
    '{16'h0, 32'hA, 32'h0, 32'hA, 1'b1}, '{16'h0, 32'hA, 32'h0, 32'h9, 1'b0},
    '{16'h1, 32'hA, 32'h0, 32'hA, 1'b1}, '{16'h1, 32'hA, 32'h0, 32'hB, 1'b0},
    '{16'h2, 32'hFFFFFFFB, 32'h5, 32'h5, 1'b1},
    '{16'h2, 32'hFFFFFFFB, 32'h5, 32'h6, 1'b0},
    '{16'h2, 32'hFFFFFFFB, 32'h5, 32'hFFFFFFFB, 1'b1},
    '{16'h3, 32'hFFFFFFFB, 32'h5, 32'h6, 1'b1},
    '{16'h3, 32'hFFFFFFFB, 32'h5, 32'h5, 1'b0},
    '{16'h4, 32'h7FFFFFF0, 32'h80000010, 32'h80000000, 1'b1},
    '{16'h4, 32'h7FFFFFF0, 32'h80000010, 32'h0, 1'b0},
    '{16'h4, 32'h7FFFFFF0, 32'h80000010, 32'h80000010, 1'b1},
    '{16'h5, 32'h7FFFFFF0, 32'h80000010, 32'h0, 1'b1},
    '{16'h5, 32'h7FFFFFF0, 32'h80000010, 32'h7FFFFFF0, 1'b0}};

  pcc_top uut (.ref_clk(ref_clk), .rst(rst), .par_addr(par_addr), .par_wr(par_wr),
    .par_rd(par_rd), .par_wdata(par_wdata), .pos_sample(pos_sample),
    .pos_valid(pos_valid), .par_rdata_ff(par_rdata_ff), .par_ack_ff(par_ack_ff),
    .par_err_ff(par_err_ff), .chan_status_ff(chan_status_ff));
  pcc_master_model u_mst (.ref_clk(ref_clk), .par_addr(par_addr), .par_wr(par_wr),
    .par_rd(par_rd), .par_wdata(par_wdata), .par_rdata_ff(par_rdata_ff),
    .par_ack_ff(par_ack_ff), .par_err_ff(par_err_ff));

  always #50 ref_clk = ~ref_clk;
  // ----
  // Shared tasks
  // ----
  task automatic cmp(input logic [31:0] g, input logic [31:0] x, input string m);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask : cmp
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic x);
    logic [31:0] q;
    logic        e;
    u_mst.xfer(1'b1, a, d, q, e);
    cmp({31'h0, e}, {31'h0, x}, "write err");
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic x);
    logic [31:0] q;
    logic        e;
    u_mst.xfer(1'b0, a, 32'h0, q, e);
    cmp({31'h0, e}, {31'h0, x}, "read err");
    cmp(q, d, "read data");
  endtask : rd
  task automatic smp(input logic [31:0] p);
    @(negedge ref_clk);
    pos_sample = p;
    pos_valid = 1'b1;
    @(negedge ref_clk);
    pos_valid = 1'b0;
  endtask : smp
  task automatic st(input int i, input logic x);
    repeat (3) @(negedge ref_clk);
    cmp({31'h0, chan_status_ff[i]}, {31'h0, x}, "status");
  endtask : st
  task automatic report_and_stop;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ----
  // Sequence
  // ----
  initial begin
    repeat (2000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    cmp({28'h0, chan_status_ff}, 32'h0, "reset status");
    rd(16'hB08, 32'h5, 1'b0);
    rd(16'hB0A, 32'h0, 1'b0);
    rd(16'hB2A, 32'h0, 1'b0);
    wr(16'hB08, 32'h6, 1'b1);
    rd(16'hB08, 32'h5, 1'b0);
    wr(16'hB26, 32'h80000000, 1'b0);
    rd(16'hB26, 32'h80000000, 1'b0);
    wr(16'hB2E, 32'h0, 1'b1);
    rd(16'h0000, 32'h80000000, 1'b1);
    $display("test registers done");
    wr(16'hB04, 32'h1, 1'b0);
    foreach (rows[i]) begin
      wr(16'hB08, {16'h0, rows[i].c}, 1'b0);
      wr(16'hB10, rows[i].a, 1'b0);
      wr(16'hB12, rows[i].b, 1'b0);
      smp(rows[i].p);
      st(0, rows[i].e);
    end
    $display("test criteria done");
    wr(16'hB08, 32'h0, 1'b0);
    st(0, 1'b1);
    wr(16'hB06, 32'h1, 1'b0);
    st(1, 1'b1);
    smp(32'hFFFFFF00);
    st(1, 1'b0);
    smp(32'h5);
    st(1, 1'b1);
    wr(16'hB06, 32'h0, 1'b0);
    smp(32'hFFFFFF00);
    st(1, 1'b1);
    wr(16'hB06, 32'h2, 1'b0);
    st(1, 1'b0);
    wr(16'hB06, 32'h3, 1'b0);
    st(1, 1'b1);
    wr(16'hB06, 32'h4, 1'b1);
    $display("test run modes done");
    wr(16'hB1C, 32'h1, 1'b0);
    wr(16'hB1E, 32'h1, 1'b0);
    st(3, 1'b0);
    wr(16'hB2C, 32'h8, 1'b0);
    st(3, 1'b1);
    st(2, 1'b0);
    wr(16'hB2C, 32'h10, 1'b1);
    $display("test group done");
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    cmp({28'h0, chan_status_ff}, 32'h0, "mid reset status");
    rd(16'hB08, 32'h5, 1'b0);
    rd(16'hB26, 32'h0, 1'b0);
    rd(16'hB2C, 32'h0, 1'b0);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule : position_compare_channels_test
